// *** design/rmh_consts.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the host signal block.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus, one register per word.
// Notes: Times are kept in their own units and converted to cycles here.
`ifndef RMH_CONSTS_SVH
`define RMH_CONSTS_SVH

`define RMH_CLK_HZ 10000000
`define RMH_BAUD 9600
`define RMH_BIT_CYC (`RMH_CLK_HZ / `RMH_BAUD)
`define RMH_GAP_MS 500
`define RMH_GAP_CYC (`RMH_GAP_MS * (`RMH_CLK_HZ / 1000))
`define RMH_CNT_W 11
`define RMH_GAP_W 23

`define RMH_ADR_CTRL 8'h00
`define RMH_ADR_STATUS 8'h04
`define RMH_ADR_RXDATA 8'h08
`define RMH_ADR_TXDATA 8'h0C
`define RMH_ADR_FAULT 8'h10
`define RMH_ADR_MASK 8'h14
`define RMH_ADR_BUTTON 8'h18

`define RMH_CTRL_ACK_EN 0
`define RMH_CTRL_ACK_DONE 1
`define RMH_TX_AIR_BIT 8
`define RMH_FAULT_RETRY 0
`define RMH_FAULT_OVERRUN 1
`define RMH_BTN_DEFAULTS 0
`define RMH_BTN_JOIN 1
`define RMH_PRESS_JOIN 3'h2
`define RMH_PRESS_DEFAULTS 3'h4

// Pin order {power_down_n, push_button, cmd_select, serial_in}; power_down_n and serial_in reset high, the other two low.
`define RMH_SYNC_RST 4'h9

`endif

// *** design/rmh_host_signals.sv ***
// Purpose: Host-facing UART, flow control and status pins of a radio module.
// Assumes: 10 MHz clk_in, 8N1 serial at a fixed rate, internal software on classic Wishbone.
// Notes: Software reads received bytes and writes outgoing ones; the pins follow.
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "rmh_consts.svh"
module rmh_host_signals #(
	parameter int unsigned GAP_CYC = `RMH_GAP_CYC
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic clk_en_in,
	input wire logic serial_in,
	input wire logic cmd_select_in,
	input wire logic push_button_input,
	input wire logic power_down_n_in,
	output logic serial_out,
	output logic cts_n_out,
	output logic reply_marker_out,
	output logic buffer_empty_flag_out,
	output logic fault_alert_out,
	output logic activity_indicator_out,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out
);
	import rmh_pkg::*;

	rmh_state_t s_q;
	rmh_state_t s_d;
	logic [1:0] rs_q;
	logic rst_n;
	logic [3:0] pins;
	logic rx;
	logic cmd_sel;
	logic btn;
	logic pd;
	logic take;
	logic wr;
	logic rd;
	logic pop;
	logic rd_fault;
	logic tx_load;
	logic [7:0] ev;
	logic [31:0] rdata;

	// The reset is released synchronously so no flop leaves reset on a different edge.
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rs_q <= 2'h0;
		end else begin
			rs_q <= {rs_q[0], 1'b1};
		end
	end
	assign rst_n = rs_q[1];

	rmh_sync u_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.clk_en_in(clk_en_in),
		.pins_in({power_down_n_in, push_button_input, cmd_select_in, serial_in}),
		.pins_out(pins)
	);
	assign rx = pins[0];
	assign cmd_sel = pins[1];
	assign btn = pins[2];
	assign pd = ~pins[3];

	// Side effects happen on the edge where the master samples ack high.
	assign take = wb_cyc_in & wb_stb_in & s_q.ack;
	assign wr = take & wb_we_in & wb_sel_in[0];
	assign rd = take & ~wb_we_in;
	assign pop = rd & (wb_adr_in == `RMH_ADR_RXDATA) & s_q.rx_full;
	assign rd_fault = rd & (wb_adr_in == `RMH_ADR_FAULT);
	assign tx_load = wr & (wb_adr_in == `RMH_ADR_TXDATA) & (s_q.tx_st == rmh_idle) & ~pd;
	assign ev = ((wr & (wb_adr_in == `RMH_ADR_FAULT)) ? wb_dat_in[7:0] : 8'h00)
		| {6'h00, (s_q.rx_st == rmh_stop) & (s_q.rx_cnt == 11'h000) & rx & s_q.rx_full & ~pop, 1'b0};

	always_comb begin
		rdata = 32'h0000_0000;
		unique case (wb_adr_in)
			`RMH_ADR_CTRL: rdata[`RMH_CTRL_ACK_EN] = s_q.ack_en;
			`RMH_ADR_STATUS: rdata[6:0] = {cts_n_out, pd, s_q.await_ack, buffer_empty_flag_out,
				s_q.tx_st != rmh_idle, s_q.rx_pay, s_q.rx_full};
			`RMH_ADR_RXDATA: rdata[9:0] = {s_q.rx_full, s_q.rx_pay, s_q.rx_byte};
			`RMH_ADR_FAULT: rdata[7:0] = s_q.fault;
			`RMH_ADR_MASK: rdata[7:0] = s_q.mask;
			`RMH_ADR_BUTTON: rdata[1:0] = s_q.btn_evt;
			default: rdata = 32'h0000_0000;
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.ack = wb_cyc_in & wb_stb_in & ~s_q.ack;
		if (wb_cyc_in & wb_stb_in & ~s_q.ack) begin
			s_d.dat = rdata;
		end

		if (wr & (wb_adr_in == `RMH_ADR_CTRL)) begin
			s_d.ack_en = wb_dat_in[`RMH_CTRL_ACK_EN];
			if (wb_dat_in[`RMH_CTRL_ACK_DONE] | ~wb_dat_in[`RMH_CTRL_ACK_EN]) begin
				s_d.await_ack = 1'b0;
			end
		end
		if (wr & (wb_adr_in == `RMH_ADR_MASK)) begin
			s_d.mask = wb_dat_in[7:0];
		end

		// A fresh exception wins over the clearing read in the same cycle.
		s_d.fault = (rd_fault ? 8'h00 : s_q.fault) | ev;
		if (rd_fault) begin
			s_d.alert = 1'b0;
		end
		if (|(ev & s_q.mask)) begin
			s_d.alert = 1'b1;
		end
		if (ev[`RMH_FAULT_RETRY]) begin
			s_d.await_ack = 1'b0;
		end

		if (pop) begin
			s_d.rx_full = 1'b0;
			if (s_q.rx_pay & s_q.ack_en) begin
				s_d.await_ack = 1'b1;
			end
		end

		unique case (s_q.rx_st)
			rmh_idle: begin
				if (!rx) begin
					s_d.rx_st = rmh_start;
					s_d.rx_cnt = 11'(`RMH_BIT_CYC / 2);
				end
			end
			rmh_start: begin
				if (s_q.rx_cnt != 11'h000) begin
					s_d.rx_cnt = s_q.rx_cnt - 11'h001;
				end else begin
					s_d.rx_st = rx ? rmh_idle : rmh_data;
					s_d.rx_cnt = 11'(`RMH_BIT_CYC - 1);
					s_d.rx_bit = 3'h0;
				end
			end
			rmh_data: begin
				if (s_q.rx_cnt != 11'h000) begin
					s_d.rx_cnt = s_q.rx_cnt - 11'h001;
				end else begin
					s_d.rx_sh = {rx, s_q.rx_sh[7:1]};
					s_d.rx_cnt = 11'(`RMH_BIT_CYC - 1);
					s_d.rx_bit = s_q.rx_bit + 3'h1;
					if (s_q.rx_bit == 3'h7) begin
						s_d.rx_st = rmh_stop;
					end
				end
			end
			rmh_stop: begin
				if (s_q.rx_cnt != 11'h000) begin
					s_d.rx_cnt = s_q.rx_cnt - 11'h001;
				end else begin
					s_d.rx_st = rmh_idle;
					// A byte sent against a full holding register is dropped and flagged.
					if (rx & (~s_q.rx_full | pop)) begin
						s_d.rx_full = 1'b1;
						s_d.rx_byte = s_q.rx_sh;
						s_d.rx_pay = cmd_sel;
					end
				end
			end
		endcase

		unique case (s_q.tx_st)
			rmh_idle: begin
				if (tx_load) begin
					s_d.tx_st = rmh_start;
					s_d.tx_sh = wb_dat_in[7:0];
					s_d.marker = wb_dat_in[`RMH_TX_AIR_BIT];
					s_d.tx_line = 1'b0;
					s_d.tx_cnt = 11'(`RMH_BIT_CYC - 1);
				end
			end
			rmh_start, rmh_data: begin
				if (s_q.tx_cnt != 11'h000) begin
					s_d.tx_cnt = s_q.tx_cnt - 11'h001;
				end else begin
					s_d.tx_cnt = 11'(`RMH_BIT_CYC - 1);
					if ((s_q.tx_st == rmh_data) && (s_q.tx_bit == 3'h7)) begin
						s_d.tx_st = rmh_stop;
						s_d.tx_line = 1'b1;
					end else begin
						s_d.tx_bit = (s_q.tx_st == rmh_start) ? 3'h0 : s_q.tx_bit + 3'h1;
						s_d.tx_st = rmh_data;
						s_d.tx_line = s_q.tx_sh[0];
						s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
					end
				end
			end
			rmh_stop: begin
				if (s_q.tx_cnt != 11'h000) begin
					s_d.tx_cnt = s_q.tx_cnt - 11'h001;
				end else begin
					s_d.tx_st = rmh_idle;
				end
			end
		endcase

		if (wr & (wb_adr_in == `RMH_ADR_BUTTON)) begin
			s_d.btn_evt = s_q.btn_evt & ~wb_dat_in[1:0];
		end
		s_d.btn_prev = btn;
		if (btn & ~s_q.btn_prev) begin
			s_d.presses = (s_q.presses == 3'h7) ? s_q.presses : s_q.presses + 3'h1;
			s_d.gap = 23'(GAP_CYC - 1);
		end else if (s_q.presses != 3'h0) begin
			if (s_q.gap != 23'h00_0000) begin
				s_d.gap = s_q.gap - 23'h00_0001;
			end else begin
				s_d.presses = 3'h0;
				if (s_q.presses == `RMH_PRESS_JOIN) begin
					s_d.btn_evt[`RMH_BTN_JOIN] = 1'b1;
				end
				if (s_q.presses == `RMH_PRESS_DEFAULTS) begin
					s_d.btn_evt[`RMH_BTN_DEFAULTS] = 1'b1;
				end
			end
		end

		// Powered down, the serial engines and the button logic are parked; stored data stays.
		if (pd) begin
			s_d.rx_st = rmh_idle;
			s_d.tx_st = rmh_idle;
			s_d.tx_line = 1'b1;
			s_d.presses = 3'h0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.tx_line <= 1'b1;
			s_q.marker <= 1'b1;
		end else if (clk_en_in) begin
			s_q <= s_d;
		end
	end

	assign serial_out = s_q.tx_line;
	assign cts_n_out = s_q.rx_full | pd;
	assign reply_marker_out = s_q.marker;
	assign buffer_empty_flag_out = ~s_q.rx_full & ~s_q.await_ack;
	assign fault_alert_out = s_q.alert;
	assign activity_indicator_out = (s_q.rx_st != rmh_idle) | (s_q.tx_st != rmh_idle);
	assign wb_dat_out = s_q.dat;
	assign wb_ack_out = s_q.ack;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n);

	cts_busy_a: assert property (
		clk_en_in && !pd && s_q.rx_st == rmh_stop && s_q.rx_cnt == 11'h000 && rx && !pop
		|=> cts_n_out && !buffer_empty_flag_out) else $error("cts not busy after byte");
	alert_raise_a: assert property (
		clk_en_in && |(ev & s_q.mask) |=> fault_alert_out) else $error("alert not raised");
	alert_masked_a: assert property (
		clk_en_in && !(|(ev & s_q.mask)) && !rd_fault |=> $stable(fault_alert_out))
		else $error("alert moved without cause");
	alert_clear_a: assert property (
		clk_en_in && rd_fault && !(|(ev & s_q.mask)) |=> !fault_alert_out)
		else $error("alert not cleared by read");
	marker_load_a: assert property (
		clk_en_in && tx_load |=> reply_marker_out == $past(wb_dat_in[`RMH_TX_AIR_BIT]))
		else $error("reply marker wrong");
	ack_wait_a: assert property (
		clk_en_in && pop && s_q.ack_en && s_q.rx_pay |=> !buffer_empty_flag_out)
		else $error("empty flag ignored ack wait");
	button_join_a: assert property (
		clk_en_in && !pd && s_q.presses == `RMH_PRESS_JOIN && s_q.gap == 23'h00_0000
		&& !(btn & ~s_q.btn_prev) |=> s_q.btn_evt[`RMH_BTN_JOIN]) else $error("join missed");
	tx_start_a: assert property (
		clk_en_in && tx_load ##1 clk_en_in [*8] |-> !serial_out [*1])
		else $error("start bit missing");
	cmd_select_a: assert property (
		clk_en_in && !pd && s_q.rx_st == rmh_stop && s_q.rx_cnt == 11'h000 && rx
		&& (!s_q.rx_full || pop) |=> s_q.rx_pay == $past(cmd_sel)) else $error("kind wrong");
	// Busy is checked in the same cycle, since power may return on the next one.
	power_down_a: assert property (
		clk_en_in && pd |-> cts_n_out
		##1 (s_q.rx_st == rmh_idle && s_q.tx_st == rmh_idle && serial_out))
		else $error("active while powered down");
endmodule

// *** design/rmh_pkg.sv ***
// Purpose: Types shared by the host signal block.
// Assumes: Nothing beyond the constants header.
// Notes: Serial states are Gray coded along idle, start, data, stop.
package rmh_pkg;

	typedef enum logic [1:0] {
		rmh_idle = 2'h0,
		rmh_start = 2'h1,
		rmh_data = 2'h3,
		rmh_stop = 2'h2
	} rmh_ser_t;

	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0] q;
	} rmh_sync_t;

	typedef struct packed {
		rmh_ser_t rx_st;
		logic [10:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_full;
		logic [7:0] rx_byte;
		logic rx_pay;
		rmh_ser_t tx_st;
		logic [10:0] tx_cnt;
		logic [2:0] tx_bit;
		logic [7:0] tx_sh;
		logic tx_line;
		logic marker;
		logic ack_en;
		logic await_ack;
		logic [7:0] fault;
		logic [7:0] mask;
		logic alert;
		logic btn_prev;
		logic [2:0] presses;
		logic [22:0] gap;
		logic [1:0] btn_evt;
		logic ack;
		logic [31:0] dat;
	} rmh_state_t;

endpackage

// *** design/rmh_sync.sv ***
// Purpose: Three-stage synchroniser for the asynchronous pins of the host signal block.
// Assumes: Pins are unrelated to clk_in.
// Notes: A change is taken only once stages two and three agree.
`timescale 1ns/1ps
`include "rmh_consts.svh"
module rmh_sync (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic [3:0] pins_in,
	output logic [3:0] pins_out
);
	import rmh_pkg::*;

	rmh_sync_t s_q;
	rmh_sync_t s_d;
	logic [3:0] agree;

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_bit
			// Stage one is left to settle; only stages two and three are compared.
			assign agree[i] = (s_q.s2[i] == s_q.s3[i]) ? s_q.s3[i] : s_q.q[i];
		end
	endgenerate

	always_comb begin
		s_d = s_q;
		s_d.s1 = pins_in;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		s_d.q = agree;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_q <= {4{`RMH_SYNC_RST}};
		end else if (clk_en_in) begin
			s_q <= s_d;
		end
	end

	assign pins_out = s_q.q;
endmodule

// *** testbench/rmh_host_model.sv ***
// Purpose: Host microcontroller on the far side of the host serial lines.
// Assumes: 8N1 at the block's bit period, clocked from the bench clock.
// Notes: The receiver keeps the last byte that it saw on the line.
`timescale 1ns/1ps
`include "rmh_consts.svh"
module rmh_host_model (
	input wire logic clk_in,
	input wire logic line_in,
	input wire logic cts_n_in,
	output logic line_out,
	output logic [7:0] got_out
);
	initial line_out = 1'b1;
	initial got_out = 8'h00;

	// Start, data LSB first, then stop.
	task automatic send(input logic [7:0] b);
		@(posedge clk_in);
		while (cts_n_in !== 1'b0) begin
			@(posedge clk_in);
		end
		for (int i = 0; i < 10; i++) begin
			line_out <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
			repeat (`RMH_BIT_CYC) @(posedge clk_in);
		end
	endtask

	// Samples each bit at its middle, so sync delay in the block does not matter.
	always begin
		@(negedge line_in);
		repeat (`RMH_BIT_CYC / 2) @(posedge clk_in);
		for (int i = 0; i < 8; i++) begin
			repeat (`RMH_BIT_CYC) @(posedge clk_in);
			got_out[i] <= line_in;
		end
	end
endmodule

// *** testbench/rmh_host_signals_tb_top.sv ***
// Purpose: Self-checking bench for the host signal block.
// Assumes: Register map and bus timing as handed over with the design.
// Notes: The gap timer is shortened to keep button tests brief.
`timescale 1ns/1ps
module rmh_host_signals_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_sel = 1'b0;
	logic btn = 1'b0;
	logic pd_n = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic ack, sin, sout, cts_n, marker, empty, alert, act;
	logic [7:0] got;
	logic [31:0] q;
	int bad_count = 0;
	int check_count = 0;
	int cycles = 0;

	rmh_host_signals #(.GAP_CYC(50)) uut (.clk_in(clk), .resetn_in(rst_n), .clk_en_in(1'b1),
		.serial_in(sin), .cmd_select_in(cmd_sel), .push_button_input(btn),
		.power_down_n_in(pd_n), .serial_out(sout), .cts_n_out(cts_n),
		.reply_marker_out(marker), .buffer_empty_flag_out(empty),
		.fault_alert_out(alert), .activity_indicator_out(act), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
		.wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack));

	rmh_host_model host (.clk_in(clk), .line_in(sout), .cts_n_in(cts_n), .line_out(sin),
		.got_out(got));

	always #50 clk = ~clk;

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 70000) begin
			bad_count++;
			report_and_stop();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One classic cycle; returns settled at the following falling edge.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1) begin
			@(posedge clk);
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(negedge clk);
	endtask

	task automatic press(input int n);
		repeat (n) begin
			@(posedge clk);
			btn <= 1'b1;
			repeat (20) @(posedge clk);
			btn <= 1'b0;
			repeat (20) @(posedge clk);
		end
		repeat (100) @(posedge clk);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(negedge clk);
		chk("idle pins", {cts_n, empty, alert, marker, sout, act}, 6'b010110);
		host.send(8'hAB);
		@(negedge clk);
		chk("cts busy", cts_n, 1'b1);
		chk("empty held", empty, 1'b0);
		bus(1'b1, 8'h1C, 32'h0000_00FF);
		bus(1'b0, 8'h1C, 32'h0000_0000);
		chk("unmapped", q, 32'h0000_0000);
		bus(1'b0, 8'h08, 32'h0000_0000);
		chk("rx cmd", q, 32'h0000_02AB);
		chk("cts ready", cts_n, 1'b0);
		chk("empty free", empty, 1'b1);
		bus(1'b1, 8'h0C, 32'h0000_0035);
		chk("marker reply", marker, 1'b0);
		chk("activity tx", act, 1'b1);
		repeat (10600) @(posedge clk);
		chk("tx reply", got, 8'h35);
		bus(1'b1, 8'h0C, 32'h0000_01C4);
		chk("marker air", marker, 1'b1);
		repeat (10600) @(posedge clk);
		chk("tx air", got, 8'hC4);
		bus(1'b1, 8'h00, 32'h0000_0001);
		@(posedge clk);
		cmd_sel <= 1'b1;
		host.send(8'h5A);
		@(negedge clk);
		bus(1'b0, 8'h08, 32'h0000_0000);
		chk("rx payload", q, 32'h0000_035A);
		chk("empty await", empty, 1'b0);
		bus(1'b1, 8'h00, 32'h0000_0003);
		chk("empty acked", empty, 1'b1);
		bus(1'b1, 8'h14, 32'h0000_0001);
		bus(1'b1, 8'h10, 32'h0000_0002);
		@(negedge clk);
		chk("alert masked", alert, 1'b0);
		bus(1'b1, 8'h10, 32'h0000_0001);
		@(negedge clk);
		chk("alert set", alert, 1'b1);
		bus(1'b0, 8'h10, 32'h0000_0000);
		chk("fault read", q, 32'h0000_0003);
		@(negedge clk);
		chk("alert clear", alert, 1'b0);
		for (int k = 0; k < 2; k++) begin
			press(k ? 4 : 2);
			bus(1'b0, 8'h18, 32'h0000_0000);
			chk("button", q, k ? 32'h0000_0001 : 32'h0000_0002);
			bus(1'b1, 8'h18, 32'h0000_0003);
		end
		@(posedge clk);
		pd_n <= 1'b0;
		repeat (10) @(negedge clk);
		chk("cts power down", cts_n, 1'b1);
		report_and_stop();
	end
endmodule
